// ### verilog/pwmlc_consts.vh
`ifndef PWMLC_CONSTS_VH
`define PWMLC_CONSTS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PWMLC_OFS_CTRL_A   8'h00
`define PWMLC_OFS_CTRL_B   8'h04
`define PWMLC_OFS_XBUF     8'h08
`define PWMLC_OFS_DIVCTL   8'h0C
`define PWMLC_OFS_STATUS   8'h10

// ---------------------------------------------------------------
// register index codes
// ---------------------------------------------------------------
`define PWMLC_IDX_CTRL_A   3'h0
`define PWMLC_IDX_CTRL_B   3'h1
`define PWMLC_IDX_XBUF     3'h2
`define PWMLC_IDX_DIVCTL   3'h3
`define PWMLC_IDX_STATUS   3'h4
`define PWMLC_IDX_NONE     3'h7

// ---------------------------------------------------------------
// fields of pwm_control_a
// ---------------------------------------------------------------
`define PWMLC_A_RES_LSB    0
`define PWMLC_A_RES_MSB    1
`define PWMLC_A_RUN_LSB    2
`define PWMLC_A_RUN_MSB    5
`define PWMLC_A_ABORT      6

// ---------------------------------------------------------------
// fields of pwm_control_b and divider_control
// ---------------------------------------------------------------
`define PWMLC_B_HALF       0
`define PWMLC_B_CHS_LSB    1
`define PWMLC_B_CHS_MSB    2
`define PWMLC_D_DIVSEL     5

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define PWMLC_S_HOLD       16
`define PWMLC_S_PEND_LSB   20
`define PWMLC_S_PEND_MSB   23

// ---------------------------------------------------------------
// widths and counts
// ---------------------------------------------------------------
`define PWMLC_CW           14
`define PWMLC_CNT_ONES     14'h3FFF
`define PWMLC_DIV4_MASK    3'h3
`define PWMLC_DIV8_MASK    3'h7
`define PWMLC_HI6_MASK     6'h3F
`define PWMLC_HI4_MASK     6'h0F
`define PWMLC_ZERO32       32'h0000_0000
`define PWMLC_ZERO8        8'h00

`endif

// ### verilog/pwmlc_apb.v
`timescale 1ns/10ps
`include "pwmlc_consts.vh"

module pwmlc_apb (
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   output wire        wr_stb,
   output wire        rd_stb,
   output wire [2:0]  reg_idx,
   output wire        hit,
   output wire        pready
);

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function [2:0] dec_idx;
      input [7:0] a;
      begin
         case (a)
            `PWMLC_OFS_CTRL_A: dec_idx = `PWMLC_IDX_CTRL_A;
            `PWMLC_OFS_CTRL_B: dec_idx = `PWMLC_IDX_CTRL_B;
            `PWMLC_OFS_XBUF:   dec_idx = `PWMLC_IDX_XBUF;
            `PWMLC_OFS_DIVCTL: dec_idx = `PWMLC_IDX_DIVCTL;
            `PWMLC_OFS_STATUS: dec_idx = `PWMLC_IDX_STATUS;
            default:           dec_idx = `PWMLC_IDX_NONE;
         endcase
      end
   endfunction

   assign reg_idx = dec_idx(paddr);
   assign hit     = (reg_idx != `PWMLC_IDX_NONE);
   assign pready  = psel & penable;
   assign wr_stb  = psel & penable & pwrite & hit;
   assign rd_stb  = psel & ~penable & ~pwrite;

endmodule

// ### verilog/pwmlc_chan.v
`timescale 1ns/10ps
`include "pwmlc_consts.vh"

module pwmlc_chan (
   input  wire                  clk,
   input  wire                  rst_n,
   input  wire [`PWMLC_CW-1:0]  cnt,
   input  wire                  load,
   input  wire [`PWMLC_CW-1:0]  load_val,
   input  wire                  res12,
   input  wire                  run,
   input  wire                  abort,
   output wire                  zero_data,
   output reg                   out_n
);

   reg  [`PWMLC_CW-1:0] latch_r;
   wire [`PWMLC_CW-1:0] cmp;
   wire [`PWMLC_CW-1:0] duty;

   // ---------------------------------------------------------------
   // data latch
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_r <= `PWMLC_CNT_ONES ^ `PWMLC_CNT_ONES;
      end else if (load) begin
         latch_r <= load_val;
      end
   end

   // ---------------------------------------------------------------
   // zero detect, compare and pin
   // ---------------------------------------------------------------
   assign zero_data = res12 ? (latch_r[7:0] == `PWMLC_ZERO8)
                            : (latch_r == {`PWMLC_CW{1'b0}});
   assign cmp  = res12 ? {2'b00, cnt[11:0]} : cnt;
   assign duty = res12 ? {2'b00, latch_r[11:0]} : latch_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_n <= 1'b1;
      end else if (abort || !run) begin
         out_n <= 1'b1;
      end else begin
         out_n <= ~(cmp < duty);
      end
   end

endmodule

// ### verilog/pwmlc_top.v
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "pwmlc_consts.vh"

//Contract
//- one shared free running counter
//- reset, stop, abort force counter all ones
//- all run controls zero holds counter
//- 12-bit zero low byte holds counter
//- 14-bit zero latch holds counter
//- abort drives all pins high at once
//- run control starts channel waveform
//- latch loads only at counter all ones
//- held counter loads latch at once
//- running counter defers load to next period
//- upper write keeps buffered low byte
//- abort control clears itself
//- resolution zero 14-bit, one 12-bit for channels 0 and 1; channels 2 and 3 always 12-bit
//- half select routes low or upper
//- divider fc/4 or fc/8 by select
module pwmlc_top (
   input  wire        REF_CLK,
   input  wire        RESET_N,
   input  wire        STOP_MODE,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output reg         PSLVERR,
   output wire        PULSE_OUT_CH0_N,
   output wire        PULSE_OUT_CH1_N,
   output wire        PULSE_OUT_CH2_N,
   output wire        PULSE_OUT_CH3_N
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   reg  [1:0]           rst_sync_r;
   wire                 rst_n;
   reg  [2:0]           stop_sync_r;
   reg                  stop_r;
   reg  [1:0]           res_sel_r;
   reg  [3:0]           channel_run_r;
   reg                  pwm_abort_r;
   reg                  byte_half_select_r;
   reg  [1:0]           latch_channel_select_r;
   reg                  first_divider_input_select_r;
   reg  [7:0]           buf_lo_r;
   reg  [`PWMLC_CW-1:0] stage_r [0:3];
   reg  [3:0]           pend_r;
   reg  [3:0]           pend_nxt;
   reg  [2:0]           div_r;
   reg  [`PWMLC_CW-1:0] cnt_r;
   reg  [`PWMLC_CW-1:0] cnt_nxt;
   wire                 wr_stb;
   wire                 rd_stb;
   wire [2:0]           reg_idx;
   wire                 hit;
   wire                 tick;
   wire                 cnt_full;
   wire                 hold;
   wire [3:0]           zero_data;
   wire [3:0]           load;
   wire [3:0]           res12;
   wire [3:0]           pins_n;
   wire                 wr_a;
   wire                 wr_b;
   wire                 wr_buf;
   wire                 wr_div;
   reg  [31:0]          rd_val;
   integer              k;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [5:0] hi_mask;
      input [1:0] ch;
      begin
         hi_mask = ch[1] ? `PWMLC_HI4_MASK : `PWMLC_HI6_MASK;
      end
   endfunction

   // ---------------------------------------------------------------
   // reset release and stop synchroniser
   // ---------------------------------------------------------------
   always @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         stop_sync_r <= 3'b000;
         stop_r      <= 1'b0;
      end else begin
         stop_sync_r <= {stop_sync_r[1:0], STOP_MODE};
         if (stop_sync_r[1] == stop_sync_r[2]) begin
            stop_r <= stop_sync_r[2];
         end
      end
   end

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   pwmlc_apb u_apb (
      .psel    (PSEL),
      .penable (PENABLE),
      .pwrite  (PWRITE),
      .paddr   (PADDR),
      .wr_stb  (wr_stb),
      .rd_stb  (rd_stb),
      .reg_idx (reg_idx),
      .hit     (hit),
      .pready  (PREADY)
   );

   assign wr_a   = wr_stb & (reg_idx == `PWMLC_IDX_CTRL_A);
   assign wr_b   = wr_stb & (reg_idx == `PWMLC_IDX_CTRL_B);
   assign wr_buf = wr_stb & (reg_idx == `PWMLC_IDX_XBUF);
   assign wr_div = wr_stb & (reg_idx == `PWMLC_IDX_DIVCTL);

   always @* begin
      rd_val = `PWMLC_ZERO32;
      case (reg_idx)
         `PWMLC_IDX_CTRL_A: begin
            rd_val[`PWMLC_A_RES_MSB:`PWMLC_A_RES_LSB] = res_sel_r;
            rd_val[`PWMLC_A_RUN_MSB:`PWMLC_A_RUN_LSB] = channel_run_r;
         end
         `PWMLC_IDX_CTRL_B: begin
            rd_val[`PWMLC_B_HALF] = byte_half_select_r;
            rd_val[`PWMLC_B_CHS_MSB:`PWMLC_B_CHS_LSB] = latch_channel_select_r;
         end
         `PWMLC_IDX_DIVCTL: begin
            rd_val[`PWMLC_D_DIVSEL] = first_divider_input_select_r;
         end
         `PWMLC_IDX_STATUS: begin
            rd_val[`PWMLC_CW-1:0] = cnt_r;
            rd_val[`PWMLC_S_HOLD] = hold;
            rd_val[`PWMLC_S_PEND_MSB:`PWMLC_S_PEND_LSB] = pend_r;
         end
         default: begin
            rd_val = `PWMLC_ZERO32;
         end
      endcase
   end

   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         PRDATA  <= `PWMLC_ZERO32;
         PSLVERR <= 1'b0;
      end else if (rd_stb) begin
         PRDATA  <= rd_val;
         PSLVERR <= ~hit;
      end else if (PSEL && !PENABLE) begin
         PSLVERR <= ~hit;
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         res_sel_r                    <= 2'b00;
         channel_run_r                <= 4'h0;
         pwm_abort_r                  <= 1'b0;
         byte_half_select_r           <= 1'b0;
         latch_channel_select_r       <= 2'b00;
         first_divider_input_select_r <= 1'b0;
      end else if (stop_r) begin
         res_sel_r              <= 2'b00;
         channel_run_r          <= 4'h0;
         pwm_abort_r            <= 1'b0;
         byte_half_select_r     <= 1'b0;
         latch_channel_select_r <= 2'b00;
      end else begin
         pwm_abort_r <= wr_a & PWDATA[`PWMLC_A_ABORT];
         if (wr_a) begin
            res_sel_r <= PWDATA[`PWMLC_A_RES_MSB:`PWMLC_A_RES_LSB];
            if (PWDATA[`PWMLC_A_ABORT]) begin
               channel_run_r <= 4'h0;
            end else begin
               channel_run_r <= PWDATA[`PWMLC_A_RUN_MSB:`PWMLC_A_RUN_LSB];
            end
         end
         if (wr_b) begin
            byte_half_select_r     <= PWDATA[`PWMLC_B_HALF];
            latch_channel_select_r <= PWDATA[`PWMLC_B_CHS_MSB:`PWMLC_B_CHS_LSB];
         end
         if (wr_div) begin
            first_divider_input_select_r <= PWDATA[`PWMLC_D_DIVSEL];
         end
      end
   end

   // ---------------------------------------------------------------
   // transfer buffer and staging
   // ---------------------------------------------------------------
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         buf_lo_r <= `PWMLC_ZERO8;
         for (k = 0; k < 4; k = k + 1) begin
            stage_r[k] <= {`PWMLC_CW{1'b0}};
         end
      end else if (wr_buf) begin
         if (!byte_half_select_r) begin
            buf_lo_r <= PWDATA[7:0];
         end else begin
            stage_r[latch_channel_select_r] <=
               {PWDATA[5:0] & hi_mask(latch_channel_select_r), buf_lo_r};
         end
      end
   end

   always @* begin
      pend_nxt = pend_r & ~load;
      if (wr_buf && byte_half_select_r) begin
         pend_nxt[latch_channel_select_r] = 1'b1;
      end
   end

   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 4'h0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   assign load = pend_r & {4{cnt_full}};

   // ---------------------------------------------------------------
   // first divider and shared counter
   // ---------------------------------------------------------------
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 3'b000;
      end else begin
         div_r <= div_r + 3'b001;
      end
   end

   assign tick = first_divider_input_select_r
               ? ((div_r & `PWMLC_DIV8_MASK) == `PWMLC_DIV8_MASK)
               : ((div_r & `PWMLC_DIV4_MASK) == `PWMLC_DIV4_MASK);

   assign res12 = {2'b11, res_sel_r};
   assign hold  = stop_r | pwm_abort_r
                | (channel_run_r == 4'h0)
                | ((zero_data | ~channel_run_r) == 4'hF);
   assign cnt_full = (cnt_r == `PWMLC_CNT_ONES);

   always @* begin
      if (hold) begin
         cnt_nxt = `PWMLC_CNT_ONES;
      end else if (tick) begin
         cnt_nxt = cnt_r + {{(`PWMLC_CW-1){1'b0}}, 1'b1};
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= `PWMLC_CNT_ONES;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ch
         pwmlc_chan u_chan (
            .clk       (REF_CLK),
            .rst_n     (rst_n),
            .cnt       (cnt_r),
            .load      (load[g]),
            .load_val  (stage_r[g]),
            .res12     (res12[g]),
            .run       (channel_run_r[g]),
            .abort     (pwm_abort_r),
            .zero_data (zero_data[g]),
            .out_n     (pins_n[g])
         );
      end
   endgenerate

   assign PULSE_OUT_CH0_N = pins_n[0];
   assign PULSE_OUT_CH1_N = pins_n[1];
   assign PULSE_OUT_CH2_N = pins_n[2];
   assign PULSE_OUT_CH3_N = pins_n[3];

endmodule

// ### tb/pwmlc_sva.sv
`timescale 1ns/10ps
`include "pwmlc_consts.vh"

module pwmlc_sva (
   input wire        REF_CLK,
   input wire        RESET_N,
   input wire        STOP_MODE,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [7:0]  PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   input wire        PULSE_OUT_CH0_N,
   input wire        PULSE_OUT_CH1_N,
   input wire        PULSE_OUT_CH2_N,
   input wire        PULSE_OUT_CH3_N
);
   // ---------------------------------------------
   // run bits as written by software
   // ---------------------------------------------
   reg  [3:0] run_r;
   wire       acc  = PSEL & PENABLE;
   wire       wr_a = acc & PWRITE & (PADDR == `PWMLC_OFS_CTRL_A);
   wire       rd_a = acc & !PWRITE & (PADDR == `PWMLC_OFS_CTRL_A);
   wire       rd_s = acc & !PWRITE & (PADDR == `PWMLC_OFS_STATUS);
   wire [3:0] pins = {PULSE_OUT_CH3_N, PULSE_OUT_CH2_N, PULSE_OUT_CH1_N, PULSE_OUT_CH0_N};

   always @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         run_r <= 4'h0;
      end else if (wr_a) begin
         run_r <= PWDATA[6] ? 4'h0 : PWDATA[5:2];
      end
   end

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   abort_pins_a: assert property (wr_a & PWDATA[6] |-> ##2 (pins == 4'hF) [*2])
      else $error("pins not high after abort");
   abort_clear_a: assert property (rd_a |-> PRDATA[6] == 1'b0)
      else $error("abort bit reads one");
   hold_ones_a: assert property (rd_s && PRDATA[16] |-> PRDATA[13:0] == 14'h3FFF)
      else $error("held counter not all ones");
   stop_pins_a: assert property ($rose(STOP_MODE) |-> ##[1:8] pins == 4'hF)
      else $error("pins not high in stop mode");
   idle_ch0_a: assert property (!run_r[0] && !$past(run_r[0]) |-> PULSE_OUT_CH0_N)
      else $error("stopped channel 0 pin low");
   idle_ch1_a: assert property (!run_r[1] && !$past(run_r[1]) |-> PULSE_OUT_CH1_N)
      else $error("stopped channel 1 pin low");
   idle_ch2_a: assert property (!run_r[2] && !$past(run_r[2]) |-> PULSE_OUT_CH2_N)
      else $error("stopped channel 2 pin low");
   idle_ch3_a: assert property (!run_r[3] && !$past(run_r[3]) |-> PULSE_OUT_CH3_N)
      else $error("stopped channel 3 pin low");
   bad_addr_a: assert property (acc && PADDR > `PWMLC_OFS_STATUS |-> PSLVERR)
      else $error("unmapped access without error");
endmodule

bind pwmlc_top pwmlc_sva u_sva (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .STOP_MODE(STOP_MODE), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PULSE_OUT_CH0_N(PULSE_OUT_CH0_N), .PULSE_OUT_CH1_N(PULSE_OUT_CH1_N),
   .PULSE_OUT_CH2_N(PULSE_OUT_CH2_N), .PULSE_OUT_CH3_N(PULSE_OUT_CH3_N));

// ### tb/test_pwmlc_top.sv
`timescale 1ns/10ps
`include "pwmlc_consts.vh"

module test_pwmlc_top;
   reg         clk       = 1'b0;
   reg         reset_n   = 1'b0;
   reg         stop_mode = 1'b0;
   reg         psel      = 1'b0;
   reg         penable   = 1'b0;
   reg         pwrite    = 1'b0;
   reg  [7:0]  paddr     = 8'h00;
   reg  [31:0] pwdata    = 32'h0000_0000;
   reg  [31:0] seed      = 32'h0000_0658;
   reg  [31:0] rdat;
   reg  [31:0] c1;
   reg         perr;
   reg  [3:0]  mask;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire [3:0]  pins;
   integer     fail_count  = 0;
   integer     check_count = 0;
   integer     i;

   always #10 clk = ~clk;

   pwmlc_top uut (
      .REF_CLK(clk), .RESET_N(reset_n), .STOP_MODE(stop_mode), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PULSE_OUT_CH0_N(pins[0]), .PULSE_OUT_CH1_N(pins[1]),
      .PULSE_OUT_CH2_N(pins[2]), .PULSE_OUT_CH3_N(pins[3]));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input [127:0] name, input [31:0] exp, input [31:0] got);
      check_count = check_count + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
   endtask

   task apb(input wr, input [7:0] a, input [31:0] d);
      integer n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
         n = n + 1;
         @(posedge clk);
      end
      if (n == 16) chk("pready", 1, 0);
      rdat = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task load(input [1:0] ch, input [7:0] lo, input [5:0] hi);
      apb(1, `PWMLC_OFS_CTRL_B, {29'h0, ch, 1'b0});
      apb(1, `PWMLC_OFS_XBUF, {24'h0, lo});
      apb(1, `PWMLC_OFS_CTRL_B, {29'h0, ch, 1'b1});
      apb(1, `PWMLC_OFS_XBUF, {26'h0, hi});
   endtask

   task rnd_load(input [1:0] ch);
      seed = lfsr(seed);
      load(ch, seed[7:0] | 8'h01, seed[13:8] & (ch < 2 ? `PWMLC_HI6_MASK : `PWMLC_HI4_MASK));
   endtask

   task stat;
      apb(0, `PWMLC_OFS_STATUS, 32'h0000_0000);
   endtask

   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      stat;
      chk("reset_stat", 32'h0001_3FFF, rdat & 32'h00F1_3FFF);
      apb(0, 8'h14, 32'h0000_0000);
      chk("slverr", 1, {31'h0, perr});
      chk("bad_rdata", 0, rdat);
      for (i = 0; i < 4; i = i + 1) begin
         rnd_load(i[1:0]);
         stat;
         chk("pend_held", 0, {28'h0, rdat[23:20]});
      end
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0004);
      i = 0;
      while (pins[0] !== 1'b0 && i < 40) begin
         i = i + 1;
         @(posedge clk);
      end
      chk("pins_run0", 32'hE, {28'h0, pins});
      for (i = 0; i < 2; i = i + 1) begin
         apb(1, `PWMLC_OFS_DIVCTL, i << 5);
         stat;
         c1 = rdat;
         repeat (29) @(posedge clk);
         stat;
         chk("run_flag", 0, {31'h0, rdat[16]});
         chk("count_step", i ? 4 : 8, (rdat - c1) & 32'h0000_3FFF);
      end
      apb(1, `PWMLC_OFS_DIVCTL, 32'h0000_0000);
      mask = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
         rnd_load(i[1:0]);
         mask = mask | (4'h1 << i);
         stat;
         chk("pend_run", mask, {28'h0, rdat[23:20]});
      end
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0040);
      repeat (2) @(posedge clk);
      chk("pins_abort", 32'hF, {28'h0, pins});
      stat;
      chk("abort_stat", 32'h0001_3FFF, rdat & 32'h00F1_3FFF);
      apb(0, `PWMLC_OFS_CTRL_A, 32'h0000_0000);
      chk("ctrl_a", 0, rdat);
      load(1, 8'h00, 6'h00);
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0008);
      stat;
      chk("hold_z14", 1, {31'h0, rdat[16]});
      load(2, 8'h00, 6'h05);
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0010);
      stat;
      chk("hold_z12", 1, {31'h0, rdat[16]});
      load(2, 8'h21, 6'h05);
      repeat (2) @(posedge clk);
      stat;
      chk("run_nz12", 0, {31'h0, rdat[16]});
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0000);
      repeat (2) @(posedge clk);
      stat;
      chk("hold_norun", 1, {31'h0, rdat[16]});
      // channel 0 in 12-bit mode: zero low byte holds, 14-bit does not
      load(0, 8'h00, 6'h07);
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0005);
      stat;
      chk("hold_z12c0", 1, {31'h0, rdat[16]});
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0004);
      stat;
      chk("run_14c0", 0, {31'h0, rdat[16]});
      apb(1, `PWMLC_OFS_CTRL_A, 32'h0000_0010);
      stop_mode <= 1'b1;
      repeat (8) @(posedge clk);
      stop_mode <= 1'b0;
      repeat (4) @(posedge clk);
      stat;
      chk("hold_stop", 32'h0001_3FFF, rdat & 32'h0001_3FFF);
      chk("pins_stop", 32'hF, {28'h0, pins});
      give_verdict;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count = fail_count + 1;
      give_verdict;
   end
endmodule
